/* File: pkg/aeb_consts.svh */
// Purpose: constants of the arithmetic, compare, skip and branch execution unit
// Assumes: one 20 MHz core clock, operands delivered already decoded
// Notes: flag positions follow the core status byte (I T H S V N Z C)
// Functional notes
// - add registers, optional carry-in, full flag update
// - subtract registers, optional borrow, full flag update
// - subtract constant, optional borrow, full flags
// - conjunction; Z N V S only, C H kept
// - inclusive/exclusive disjunction; Z N V S only
// - set mask bits by disjunction, Z N V S
// - clear mask bits using FFh minus constant
// - test register against itself, value unchanged
// - compares set all arithmetic flags, no write
// - equal compare skips next, one/two cycles
// - register bit test skips, one/two cycles
// - I/O bit test skips, one/two cycles
// - flag branch target PC plus offset plus one
// - unsigned via carry; equal zero; sign negative
// - signed branches use negative xor overflow
// - branches on half-carry, transfer bit, overflow
// - branches on global interrupt enable flag
`ifndef AEB_CONSTS_SVH
`define AEB_CONSTS_SVH

`define AEB_PC_W 12
`define AEB_PC_RST 12'h000
`define AEB_PC_STEP 12'h001
`define AEB_SKIP_SHORT 12'h002
`define AEB_SKIP_LONG 12'h003
`define AEB_FLAGS_RST 8'h00
`define AEB_MASK_ALL 8'hFF
`define AEB_F_C 0
`define AEB_F_Z 1
`define AEB_F_N 2
`define AEB_F_V 3
`define AEB_F_S 4
`define AEB_F_H 5
`define AEB_F_T 6
`define AEB_F_I 7
`define AEB_CYC_ONE 3'h1
`define AEB_CYC_TAKEN 3'h2
`define AEB_CYC_JUMP 3'h2
`define AEB_CYC_CALL 3'h3
`define AEB_CYC_RET 3'h4
`define AEB_STACK_AW 2

`endif

/* File: pkg/aeb_pkg.sv */
// Purpose: types of the execution unit
// Assumes: widths are written out here; the constants header is not included
// Notes: operation codes are a decoded form, not instruction words
package aeb_pkg;
	typedef enum logic [4:0] {
		OP_NOP = 5'h00,
		OP_ADD = 5'h01,
		OP_ADD_CARRY = 5'h02,
		OP_SUB = 5'h03,
		OP_DIFFERENCE_WITH_BORROW = 5'h04,
		OP_IMMEDIATE_DIFFERENCE = 5'h05,
		OP_IMMEDIATE_BORROW_DIFFERENCE = 5'h06,
		OP_AND = 5'h07,
		OP_IMMEDIATE_CONJUNCTION = 5'h08,
		OP_OR = 5'h09,
		OP_IMMEDIATE_DISJUNCTION = 5'h0A,
		OP_EXCLUSIVE_DISJUNCTION = 5'h0B,
		OP_SET_MASK_BITS = 5'h0C,
		OP_CLEAR_MASK_BITS = 5'h0D,
		OP_ZERO_MINUS_CHECK = 5'h0E,
		OP_COMPARE_REGISTERS = 5'h0F,
		OP_COMPARE_WITH_BORROW = 5'h10,
		OP_IMMEDIATE_COMPARE = 5'h11,
		OP_EQUAL_COMPARE_SKIP = 5'h12,
		OP_SKIP_ON_REGISTER_BIT_LOW = 5'h13,
		OP_SKIP_ON_REGISTER_BIT_HIGH = 5'h14,
		OP_SKIP_ON_IO_BIT_LOW = 5'h15,
		OP_SKIP_ON_IO_BIT_HIGH = 5'h16,
		OP_FLAG_SET_BRANCH = 5'h17,
		OP_FLAG_CLEAR_BRANCH = 5'h18,
		OP_RELATIVE_JUMP = 5'h19,
		OP_RELATIVE_SUBROUTINE_CALL = 5'h1A,
		OP_SUBROUTINE_RETURN = 5'h1B,
		OP_INTERRUPT_RETURN = 5'h1C
	} aeb_op_t;

	typedef enum logic [1:0] {
		ST_READY = 2'b01,
		ST_WAIT = 2'b10
	} aeb_state_t;
endpackage

/* File: hdl/aeb_stack.sv */
// Purpose: return-address stack of the execution unit
// Assumes: push and pop never asserted together
// Notes: circular; overflow silently overwrites the oldest entry
`timescale 1ns/1ps
`include "aeb_consts.svh"
module aeb_stack (
	input wire logic clk,
	input wire logic rst,
	input wire logic push,
	input wire logic pop,
	input wire logic [`AEB_PC_W-1:0] push_data,
	output logic [`AEB_PC_W-1:0] top_q
);
	logic [`AEB_PC_W-1:0] mem_q [0:(1<<`AEB_STACK_AW)-1];
	logic [`AEB_STACK_AW-1:0] ptr_q;
	logic [`AEB_STACK_AW-1:0] below;

	assign below = ptr_q - 2'd2;

	// entries carry no reset; only the pointer and the top copy need one
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[ptr_q] <= push_data;
		end
	end

	// pointer moves with push and pop, wrapping on overflow
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ptr_q <= '0;
		end else if (push) begin
			ptr_q <= ptr_q + 2'd1;
		end else if (pop) begin
			ptr_q <= ptr_q - 2'd1;
		end
	end

	// registered copy of the top entry, so a pop sees it without a read cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			top_q <= `AEB_PC_RST;
		end else if (push) begin
			top_q <= push_data;
		end else if (pop) begin
			top_q <= mem_q[below];
		end
	end
endmodule // aeb_stack

/* File: hdl/aeb_exec.sv */
// Purpose: executes arithmetic, logic, compare, skip and relative branch operations
// Assumes: operands and decoded operation come from same-clock core logic
// Notes: an operation is taken when INSTR_VALID and INSTR_READY are both high
`timescale 1ns/1ps
`include "aeb_consts.svh"
module aeb_exec
	import aeb_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RESET,
	input wire logic INSTR_VALID,
	input wire aeb_op_t OP,
	input wire logic [4:0] DST_ADDR,
	input wire logic [7:0] RD_DATA,
	input wire logic [7:0] RR_DATA,
	input wire logic [7:0] IMM_K,
	input wire logic [2:0] BIT_SEL,
	input wire logic [2:0] FLAG_SEL,
	input wire logic [`AEB_PC_W-1:0] OFFSET,
	input wire logic [7:0] IO_DATA,
	input wire logic SKIP_LONG,
	output logic INSTR_READY,
	output logic WB_VALID,
	output logic [4:0] WB_ADDR,
	output logic [7:0] WB_DATA,
	output logic [7:0] FLAGS,
	output logic [`AEB_PC_W-1:0] PC
);
	aeb_state_t state_q;
	logic [2:0] cnt_q;
	logic [2:0] cyc_d;
	logic acc;
	logic [7:0] opb;
	logic [8:0] sum;
	logic [7:0] res;
	logic [7:0] flags_d;
	logic is_add, is_sub, is_logic, writes, cin_used;
	logic skip, take;
	logic [`AEB_PC_W-1:0] pc_d;
	logic [`AEB_PC_W-1:0] stack_top;
	logic push, pop;

	assign acc = INSTR_VALID && INSTR_READY;

	// operand selection: register, constant, inverted mask or self
	always_comb begin
		opb = RR_DATA;
		unique case (OP)
			OP_IMMEDIATE_DIFFERENCE, OP_IMMEDIATE_BORROW_DIFFERENCE, OP_IMMEDIATE_CONJUNCTION,
			OP_IMMEDIATE_DISJUNCTION, OP_SET_MASK_BITS, OP_IMMEDIATE_COMPARE: opb = IMM_K;
			OP_CLEAR_MASK_BITS: opb = `AEB_MASK_ALL - IMM_K;
			OP_ZERO_MINUS_CHECK: opb = RD_DATA;
			default: opb = RR_DATA;
		endcase
	end

	// operation classes
	always_comb begin
		is_add = (OP == OP_ADD) || (OP == OP_ADD_CARRY);
		is_sub = (OP == OP_SUB) || (OP == OP_DIFFERENCE_WITH_BORROW) || (OP == OP_IMMEDIATE_DIFFERENCE)
			|| (OP == OP_IMMEDIATE_BORROW_DIFFERENCE) || (OP == OP_COMPARE_REGISTERS)
			|| (OP == OP_COMPARE_WITH_BORROW) || (OP == OP_IMMEDIATE_COMPARE);
		is_logic = (OP == OP_AND) || (OP == OP_IMMEDIATE_CONJUNCTION) || (OP == OP_OR)
			|| (OP == OP_IMMEDIATE_DISJUNCTION) || (OP == OP_EXCLUSIVE_DISJUNCTION)
			|| (OP == OP_SET_MASK_BITS) || (OP == OP_CLEAR_MASK_BITS) || (OP == OP_ZERO_MINUS_CHECK);
		cin_used = (OP == OP_ADD_CARRY) || (OP == OP_DIFFERENCE_WITH_BORROW)
			|| (OP == OP_IMMEDIATE_BORROW_DIFFERENCE) || (OP == OP_COMPARE_WITH_BORROW);
		// compares compute only flags, nothing is written back
		writes = (is_add || is_sub || is_logic) && (OP != OP_COMPARE_REGISTERS)
			&& (OP != OP_COMPARE_WITH_BORROW) && (OP != OP_IMMEDIATE_COMPARE);
	end

	// datapath: one nine-bit adder serves both add and subtract
	always_comb begin
		sum = 9'h000;
		res = 8'h00;
		if (is_add) begin
			sum = {1'b0, RD_DATA} + {1'b0, opb} + {8'h00, cin_used & FLAGS[`AEB_F_C]};
			res = sum[7:0];
		end else if (is_sub) begin
			sum = {1'b0, RD_DATA} - {1'b0, opb} - {8'h00, cin_used & FLAGS[`AEB_F_C]};
			res = sum[7:0];
		end else begin
			unique case (OP)
				OP_AND, OP_IMMEDIATE_CONJUNCTION, OP_CLEAR_MASK_BITS, OP_ZERO_MINUS_CHECK:
					res = RD_DATA & opb;
				OP_OR, OP_IMMEDIATE_DISJUNCTION, OP_SET_MASK_BITS: res = RD_DATA | opb;
				OP_EXCLUSIVE_DISJUNCTION: res = RD_DATA ^ opb;
				default: res = 8'h00;
			endcase
		end
	end

	// flag update; logic ops leave carry and half-carry alone
	always_comb begin
		flags_d = FLAGS;
		if (is_add) begin
			flags_d[`AEB_F_C] = sum[8];
			flags_d[`AEB_F_H] = (RD_DATA[3] & opb[3]) | (opb[3] & ~res[3]) | (~res[3] & RD_DATA[3]);
			flags_d[`AEB_F_V] = (RD_DATA[7] & opb[7] & ~res[7]) | (~RD_DATA[7] & ~opb[7] & res[7]);
		end else if (is_sub) begin
			flags_d[`AEB_F_C] = (~RD_DATA[7] & opb[7]) | (opb[7] & res[7]) | (res[7] & ~RD_DATA[7]);
			flags_d[`AEB_F_H] = (~RD_DATA[3] & opb[3]) | (opb[3] & res[3]) | (res[3] & ~RD_DATA[3]);
			flags_d[`AEB_F_V] = (RD_DATA[7] & ~opb[7] & ~res[7]) | (~RD_DATA[7] & opb[7] & res[7]);
		end else if (is_logic) begin
			flags_d[`AEB_F_V] = 1'b0;
		end
		if (is_add || is_sub || is_logic) begin
			flags_d[`AEB_F_Z] = (res == 8'h00);
			flags_d[`AEB_F_N] = res[7];
			flags_d[`AEB_F_S] = res[7] ^ flags_d[`AEB_F_V];
		end
		if (OP == OP_INTERRUPT_RETURN) begin
			flags_d[`AEB_F_I] = 1'b1;
		end
	end

	// skip and branch decisions
	always_comb begin
		skip = 1'b0;
		take = 1'b0;
		unique case (OP)
			OP_EQUAL_COMPARE_SKIP: skip = (RD_DATA == RR_DATA);
			OP_SKIP_ON_REGISTER_BIT_LOW: skip = ~RR_DATA[BIT_SEL];
			OP_SKIP_ON_REGISTER_BIT_HIGH: skip = RR_DATA[BIT_SEL];
			OP_SKIP_ON_IO_BIT_LOW: skip = ~IO_DATA[BIT_SEL];
			OP_SKIP_ON_IO_BIT_HIGH: skip = IO_DATA[BIT_SEL];
			// any flag, so C, Z, N, S, H, T, V and I branches all share this path
			OP_FLAG_SET_BRANCH: take = FLAGS[FLAG_SEL];
			OP_FLAG_CLEAR_BRANCH: take = ~FLAGS[FLAG_SEL];
			default: begin
				skip = 1'b0;
				take = 1'b0;
			end
		endcase
	end

	// next program counter and cycle count
	always_comb begin
		pc_d = PC + `AEB_PC_STEP;
		cyc_d = `AEB_CYC_ONE;
		if (skip) begin
			pc_d = PC + (SKIP_LONG ? `AEB_SKIP_LONG : `AEB_SKIP_SHORT);
			cyc_d = `AEB_CYC_TAKEN;
		end else if (take) begin
			pc_d = PC + OFFSET + `AEB_PC_STEP;
			cyc_d = `AEB_CYC_TAKEN;
		end else if (OP == OP_RELATIVE_JUMP) begin
			pc_d = PC + OFFSET + `AEB_PC_STEP;
			cyc_d = `AEB_CYC_JUMP;
		end else if (OP == OP_RELATIVE_SUBROUTINE_CALL) begin
			pc_d = PC + OFFSET + `AEB_PC_STEP;
			cyc_d = `AEB_CYC_CALL;
		end else if ((OP == OP_SUBROUTINE_RETURN) || (OP == OP_INTERRUPT_RETURN)) begin
			pc_d = stack_top;
			cyc_d = `AEB_CYC_RET;
		end
	end

	assign push = acc && (OP == OP_RELATIVE_SUBROUTINE_CALL);
	assign pop = acc && ((OP == OP_SUBROUTINE_RETURN) || (OP == OP_INTERRUPT_RETURN));

	// return address is the word after the call
	aeb_stack u_stack (
		.clk(CLOCK),
		.rst(RESET),
		.push(push),
		.pop(pop),
		.push_data(PC + `AEB_PC_STEP),
		.top_q(stack_top)
	);

	// busy sequencing: multi-cycle operations hold off the next one
	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			state_q <= ST_READY;
			cnt_q <= 3'h0;
			INSTR_READY <= 1'b1;
		end else begin
			unique case (state_q)
				ST_READY: begin
					if (acc && (cyc_d != `AEB_CYC_ONE)) begin
						state_q <= ST_WAIT;
						cnt_q <= cyc_d - 3'h1;
						INSTR_READY <= 1'b0;
					end
				end
				ST_WAIT: begin
					cnt_q <= cnt_q - 3'h1;
					if (cnt_q == 3'h1) begin
						state_q <= ST_READY;
						INSTR_READY <= 1'b1;
					end
				end
			endcase
		end
	end

	// program counter and flags change at the accepting edge
	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			PC <= `AEB_PC_RST;
			FLAGS <= `AEB_FLAGS_RST;
		end else if (acc) begin
			PC <= pc_d;
			FLAGS <= flags_d;
		end
	end

	// write-back strobe is one cycle wide
	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			WB_VALID <= 1'b0;
			WB_ADDR <= 5'h00;
			WB_DATA <= 8'h00;
		end else begin
			WB_VALID <= acc && writes;
			if (acc && writes) begin
				WB_ADDR <= DST_ADDR;
				WB_DATA <= res;
			end
		end
	end

	// helpers for the checks below
	logic [7:0] chk_sum, chk_clear_mask;
	logic [`AEB_PC_W-1:0] chk_tgt;
	assign chk_sum = RD_DATA + RR_DATA;
	assign chk_clear_mask = RD_DATA & ~IMM_K;
	assign chk_tgt = PC + OFFSET + `AEB_PC_STEP;
	logic [7:0] chk_add_carry, chk_sub_borrow, chk_sub_const, chk_or, chk_xor, chk_set_mask;
	logic chk_reg_bit, chk_io_bit, chk_flag;
	assign chk_add_carry = RD_DATA + RR_DATA + {7'h00, FLAGS[`AEB_F_C]};
	assign chk_sub_borrow = RD_DATA - RR_DATA - {7'h00, FLAGS[`AEB_F_C]};
	assign chk_sub_const = RD_DATA - IMM_K;
	assign chk_or = RD_DATA | RR_DATA;
	assign chk_xor = RD_DATA ^ RR_DATA;
	assign chk_set_mask = RD_DATA | IMM_K;
	// bit and flag picks, so skip and branch checks need no index inside $past
	assign chk_reg_bit = RR_DATA[BIT_SEL];
	assign chk_io_bit = IO_DATA[BIT_SEL];
	assign chk_flag = FLAGS[FLAG_SEL];

	a_add_result: assert property (@(posedge CLOCK) disable iff (RESET)
		acc && OP == OP_ADD |=> WB_VALID && WB_DATA == $past(chk_sum))
		else $error("add result wrong");
	a_sub_borrow: assert property (@(posedge CLOCK) disable iff (RESET)
		acc && OP == OP_SUB |=> FLAGS[`AEB_F_C] == ($past(RD_DATA) < $past(RR_DATA)))
		else $error("subtract carry wrong");
	a_logic_keeps: assert property (@(posedge CLOCK) disable iff (RESET)
		acc && is_logic |=> FLAGS[`AEB_F_C] == $past(FLAGS[`AEB_F_C]) && FLAGS[`AEB_F_H] == $past(FLAGS[`AEB_F_H])
			&& !FLAGS[`AEB_F_V])
		else $error("logic op disturbed carry flags");
	a_mask_clear: assert property (@(posedge CLOCK) disable iff (RESET)
		acc && OP == OP_CLEAR_MASK_BITS |=> WB_DATA == $past(chk_clear_mask))
		else $error("mask clear wrong");
	a_compare_nowrite: assert property (@(posedge CLOCK) disable iff (RESET)
		acc && (OP == OP_COMPARE_REGISTERS || OP == OP_IMMEDIATE_COMPARE) |=> !WB_VALID)
		else $error("compare wrote a register");
	a_skip_timing: assert property (@(posedge CLOCK) disable iff (RESET)
		acc && OP == OP_EQUAL_COMPARE_SKIP && RD_DATA == RR_DATA && !SKIP_LONG
		|=> PC == $past(PC) + `AEB_SKIP_SHORT && !INSTR_READY ##1 INSTR_READY)
		else $error("equal skip wrong");
	a_branch_target: assert property (@(posedge CLOCK) disable iff (RESET)
		acc && take |=> PC == $past(chk_tgt) && !INSTR_READY ##1 INSTR_READY)
		else $error("branch target or timing wrong");
	a_signed_less: assert property (@(posedge CLOCK) disable iff (RESET)
		acc && OP == OP_FLAG_SET_BRANCH && FLAG_SEL == 3'(`AEB_F_S) |->
			take == (FLAGS[`AEB_F_N] ^ FLAGS[`AEB_F_V]))
		else $error("signed branch decision wrong");
	a_call_cycles: assert property (@(posedge CLOCK) disable iff (RESET)
		acc && OP == OP_RELATIVE_SUBROUTINE_CALL |=> !INSTR_READY [*2] ##1 INSTR_READY)
		else $error("call not three cycles");
	a_interrupt_return_enable: assert property (@(posedge CLOCK) disable iff (RESET)
		acc && OP == OP_INTERRUPT_RETURN |=> FLAGS[`AEB_F_I] && !INSTR_READY [*3] ##1 INSTR_READY)
		else $error("interrupt return wrong");

	// arithmetic results; carry-in and borrow come from the flag before the op
	a_carry_add: assert property (@(posedge CLOCK) disable iff (RESET)
		acc && OP == OP_ADD_CARRY |=> WB_VALID && WB_DATA == $past(chk_add_carry))
		else $error("add with carry result wrong");
	a_borrow_sub: assert property (@(posedge CLOCK) disable iff (RESET)
		acc && OP == OP_DIFFERENCE_WITH_BORROW |=> WB_VALID && WB_DATA == $past(chk_sub_borrow))
		else $error("subtract with borrow result wrong");
	a_const_sub: assert property (@(posedge CLOCK) disable iff (RESET)
		acc && OP == OP_IMMEDIATE_DIFFERENCE |=> WB_VALID && WB_DATA == $past(chk_sub_const)
			&& FLAGS[`AEB_F_C] == ($past(RD_DATA) < $past(IMM_K)))
		else $error("constant subtract wrong");

	// logic results, or and exclusive or also checking overflow cleared, then immediate compare flags
	a_or_result: assert property (@(posedge CLOCK) disable iff (RESET)
		acc && OP == OP_OR |=> WB_DATA == $past(chk_or) && !FLAGS[`AEB_F_V])
		else $error("or result wrong");
	a_xor_result: assert property (@(posedge CLOCK) disable iff (RESET)
		acc && OP == OP_EXCLUSIVE_DISJUNCTION |=> WB_DATA == $past(chk_xor) && !FLAGS[`AEB_F_V])
		else $error("exclusive or result wrong");
	a_mask_set: assert property (@(posedge CLOCK) disable iff (RESET)
		acc && OP == OP_SET_MASK_BITS |=> WB_DATA == $past(chk_set_mask))
		else $error("mask set wrong");
	a_test_keeps: assert property (@(posedge CLOCK) disable iff (RESET)
		acc && OP == OP_ZERO_MINUS_CHECK |=> WB_DATA == $past(RD_DATA)
			&& FLAGS[`AEB_F_Z] == ($past(RD_DATA) == 8'h00) && FLAGS[`AEB_F_N] == $past(RD_DATA[7]))
		else $error("register test wrong");
	a_compare_flags: assert property (@(posedge CLOCK) disable iff (RESET)
		acc && OP == OP_IMMEDIATE_COMPARE |=> FLAGS[`AEB_F_C] == ($past(RD_DATA) < $past(IMM_K))
			&& FLAGS[`AEB_F_Z] == ($past(RD_DATA) == $past(IMM_K)))
		else $error("compare flags wrong");

	// skips jump two or three words with one wait cycle; no skip is a plain step
	a_skip_long: assert property (@(posedge CLOCK) disable iff (RESET)
		acc && OP == OP_EQUAL_COMPARE_SKIP && RD_DATA == RR_DATA && SKIP_LONG
		|=> PC == $past(PC) + `AEB_SKIP_LONG && !INSTR_READY ##1 INSTR_READY)
		else $error("long equal skip wrong");
	a_noskip_step: assert property (@(posedge CLOCK) disable iff (RESET)
		acc && OP == OP_EQUAL_COMPARE_SKIP && RD_DATA != RR_DATA
		|=> PC == $past(PC) + `AEB_PC_STEP && INSTR_READY)
		else $error("unequal compare skipped");
	a_regbit_skip: assert property (@(posedge CLOCK) disable iff (RESET)
		acc && !SKIP_LONG && ((OP == OP_SKIP_ON_REGISTER_BIT_LOW && !chk_reg_bit)
			|| (OP == OP_SKIP_ON_REGISTER_BIT_HIGH && chk_reg_bit))
		|=> PC == $past(PC) + `AEB_SKIP_SHORT && !INSTR_READY)
		else $error("register bit skip wrong");
	a_iobit_skip: assert property (@(posedge CLOCK) disable iff (RESET)
		acc && !SKIP_LONG && ((OP == OP_SKIP_ON_IO_BIT_LOW && !chk_io_bit)
			|| (OP == OP_SKIP_ON_IO_BIT_HIGH && chk_io_bit))
		|=> PC == $past(PC) + `AEB_SKIP_SHORT && !INSTR_READY)
		else $error("io bit skip wrong");

	// branches: untaken is one plain step, named conditions watch one flag each
	a_branch_untaken: assert property (@(posedge CLOCK) disable iff (RESET)
		acc && ((OP == OP_FLAG_SET_BRANCH && !chk_flag) || (OP == OP_FLAG_CLEAR_BRANCH && chk_flag))
		|=> PC == $past(PC) + `AEB_PC_STEP && INSTR_READY)
		else $error("untaken branch moved");
	a_carry_branch: assert property (@(posedge CLOCK) disable iff (RESET)
		acc && OP == OP_FLAG_CLEAR_BRANCH && FLAG_SEL == 3'(`AEB_F_C) && !FLAGS[`AEB_F_C]
		|=> PC == $past(chk_tgt))
		else $error("same or higher branch wrong");
	a_half_branch: assert property (@(posedge CLOCK) disable iff (RESET)
		acc && OP == OP_FLAG_CLEAR_BRANCH && FLAG_SEL == 3'(`AEB_F_H) && !FLAGS[`AEB_F_H]
		|=> PC == $past(chk_tgt))
		else $error("half carry branch wrong");
	a_enabled_branch: assert property (@(posedge CLOCK) disable iff (RESET)
		acc && OP == OP_FLAG_SET_BRANCH && FLAG_SEL == 3'(`AEB_F_I) && FLAGS[`AEB_F_I]
		|=> PC == $past(chk_tgt))
		else $error("interrupt enabled branch wrong");

	// jump and return; the popped address is compared only at the first cycle
	a_jump_cycles: assert property (@(posedge CLOCK) disable iff (RESET)
		acc && OP == OP_RELATIVE_JUMP |=> PC == $past(chk_tgt) && !INSTR_READY ##1 INSTR_READY)
		else $error("jump target or timing wrong");
	a_return_pc: assert property (@(posedge CLOCK) disable iff (RESET)
		acc && OP == OP_SUBROUTINE_RETURN
		|=> PC == $past(stack_top) && !INSTR_READY ##1 !INSTR_READY [*2] ##1 INSTR_READY)
		else $error("return address or timing wrong");

	c_skip: cover property (@(posedge CLOCK) disable iff (RESET) acc && skip);
	c_branch: cover property (@(posedge CLOCK) disable iff (RESET) acc && take);
	c_call_ret: cover property (@(posedge CLOCK) disable iff (RESET)
		push ##[1:20] pop);
	c_carry: cover property (@(posedge CLOCK) disable iff (RESET) acc && OP == OP_ADD_CARRY && FLAGS[`AEB_F_C]);
endmodule // aeb_exec

/* File: sim/alu_and_branch_execution_test.sv */
// Purpose: self-checking bench for the execution unit, reference model plus output watcher
// Assumes: register file outside, operands offered as ports, stack four deep
// Notes: returns are only issued while the model holds a pushed address
`timescale 1ns/1ps
module alu_and_branch_execution_test
	import aeb_pkg::*;
;
	typedef struct {logic [1:0] wb; logic [4:0] a; logic [7:0] d; logic [7:0] f; logic [11:0] pc; int n;} aeb_note_t;
	logic CLOCK, RESET, INSTR_VALID, SKIP_LONG, INSTR_READY, WB_VALID;
	aeb_op_t OP;
	logic [4:0] DST_ADDR, WB_ADDR;
	logic [7:0] RD_DATA, RR_DATA, IMM_K, IO_DATA, WB_DATA, FLAGS;
	logic [2:0] BIT_SEL, FLAG_SEL;
	logic [11:0] OFFSET, PC;
	aeb_note_t notes[$];
	aeb_note_t mn;
	int mc, error_cnt, checked, depth, i;
	logic [7:0] ef;
	logic [11:0] epc;
	logic [11:0] stk[4];
	logic [1:0] sp;
	logic [63:0] rv;
	aeb_op_t o;

	aeb_exec dut (.CLOCK(CLOCK), .RESET(RESET), .INSTR_VALID(INSTR_VALID), .OP(OP), .DST_ADDR(DST_ADDR),
		.RD_DATA(RD_DATA), .RR_DATA(RR_DATA), .IMM_K(IMM_K), .BIT_SEL(BIT_SEL), .FLAG_SEL(FLAG_SEL),
		.OFFSET(OFFSET), .IO_DATA(IO_DATA), .SKIP_LONG(SKIP_LONG), .INSTR_READY(INSTR_READY),
		.WB_VALID(WB_VALID), .WB_ADDR(WB_ADDR), .WB_DATA(WB_DATA), .FLAGS(FLAGS), .PC(PC));

	// 20 MHz core clock
	always #25 CLOCK = ~CLOCK;

	task automatic cmp(logic [11:0] got, logic [11:0] exp, string what);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic cmp_len(int got, int exp);
		checked++;
		if (got != exp) begin
			error_cnt++;
			$display("ERROR %0t busy length got %0d exp %0d", $time, got, exp);
		end
	endtask

	// model the op, note the outcome, then offer it until taken; returns on the taking edge
	task automatic issue(aeb_op_t op, logic [4:0] da, logic [7:0] rd, logic [7:0] rr, logic [7:0] k,
		logic [2:0] bs, logic [2:0] fs, logic [11:0] off, logic [7:0] io, logic sl);
		logic [8:0] r;
		logic [7:0] b;
		logic cin, sk, ar, lg;
		logic [11:0] np;
		aeb_note_t nt;
		int w;
		nt.wb = 0; nt.a = da; nt.d = 0; nt.n = 1;
		np = epc + 12'h001;
		sk = 0; ar = 0; lg = 0; r = 0;
		case (op)
			OP_ADD, OP_ADD_CARRY: begin
				cin = (op == OP_ADD_CARRY) & ef[0];
				r = rd + rr + cin;
				ef[5] = (rd[3:0] + rr[3:0] + cin) > 15;
				ef[3] = (rd[7] == rr[7]) && (r[7] != rd[7]);
				ar = 1; nt.wb = 1;
			end
			OP_SUB, OP_DIFFERENCE_WITH_BORROW, OP_IMMEDIATE_DIFFERENCE, OP_IMMEDIATE_BORROW_DIFFERENCE,
			OP_COMPARE_REGISTERS, OP_COMPARE_WITH_BORROW, OP_IMMEDIATE_COMPARE: begin
				b = (op inside {OP_IMMEDIATE_DIFFERENCE, OP_IMMEDIATE_BORROW_DIFFERENCE, OP_IMMEDIATE_COMPARE}) ? k : rr;
				cin = (op inside {OP_DIFFERENCE_WITH_BORROW, OP_IMMEDIATE_BORROW_DIFFERENCE, OP_COMPARE_WITH_BORROW}) & ef[0];
				r = {1'b0, rd} - b - cin;
				ef[5] = {1'b0, rd[3:0]} < ({1'b0, b[3:0]} + cin);
				ef[3] = (rd[7] != b[7]) && (r[7] != rd[7]);
				ar = 1; nt.wb = (op < OP_COMPARE_REGISTERS); // compares write nothing
			end
			OP_AND: r = rd & rr;
			OP_IMMEDIATE_CONJUNCTION: r = rd & k;
			OP_OR: r = rd | rr;
			OP_IMMEDIATE_DISJUNCTION, OP_SET_MASK_BITS: r = rd | k;
			OP_EXCLUSIVE_DISJUNCTION: r = rd ^ rr;
			OP_CLEAR_MASK_BITS: r = rd & (8'hFF - k);
			OP_ZERO_MINUS_CHECK: r = rd & rd;
			OP_EQUAL_COMPARE_SKIP: sk = (rd == rr);
			OP_SKIP_ON_REGISTER_BIT_LOW: sk = !rr[bs];
			OP_SKIP_ON_REGISTER_BIT_HIGH: sk = rr[bs];
			OP_SKIP_ON_IO_BIT_LOW: sk = !io[bs];
			OP_SKIP_ON_IO_BIT_HIGH: sk = io[bs];
			OP_FLAG_SET_BRANCH, OP_FLAG_CLEAR_BRANCH: if (ef[fs] == (op == OP_FLAG_SET_BRANCH)) begin
				np = epc + off + 12'h001; nt.n = 2;
			end
			OP_RELATIVE_JUMP: begin np = epc + off + 12'h001; nt.n = 2; end
			OP_RELATIVE_SUBROUTINE_CALL: begin
				stk[sp] = epc + 12'h001; sp++; depth = (depth < 4) ? depth + 1 : 4;
				np = epc + off + 12'h001; nt.n = 3;
			end
			OP_SUBROUTINE_RETURN, OP_INTERRUPT_RETURN: begin
				sp--; depth--; np = stk[sp]; nt.n = 4;
				if (op == OP_INTERRUPT_RETURN) ef[7] = 1;
			end
			default: ;
		endcase
		// logic group: clears overflow, leaves carry and half-carry
		if (op inside {[OP_AND:OP_ZERO_MINUS_CHECK]}) begin
			lg = 1; ef[3] = 0; nt.wb = 1; // the test writes its own value back
		end
		if (ar) ef[0] = r[8];
		if (ar | lg) begin
			ef[1] = (r[7:0] == 0); ef[2] = r[7]; ef[4] = ef[2] ^ ef[3]; nt.d = r[7:0];
		end
		if (sk) begin np = epc + (sl ? 12'h003 : 12'h002); nt.n = 2; end
		nt.f = ef; nt.pc = np; epc = np;
		notes.push_back(nt);
		INSTR_VALID <= 1; OP <= op; DST_ADDR <= da; RD_DATA <= rd; RR_DATA <= rr; IMM_K <= k;
		BIT_SEL <= bs; FLAG_SEL <= fs; OFFSET <= off; IO_DATA <= io; SKIP_LONG <= sl;
		w = 0;
		do begin @(posedge CLOCK); w++; end while (INSTR_READY !== 1'b1 && w < 10);
		// a request that is never taken is a failure, not a silent skip
		if (INSTR_READY !== 1'b1) begin
			error_cnt++;
			$display("ERROR %0t operation never taken", $time);
		end
	endtask

	// watcher: each taken op retires the oldest note
	always begin
		@(posedge CLOCK);
		if (RESET === 1'b0 && INSTR_VALID === 1'b1 && INSTR_READY === 1'b1) begin
			mn = notes.pop_front();
			#1;
			cmp(WB_VALID, mn.wb[0], "write strobe");
			if (mn.wb == 1) cmp(WB_DATA, mn.d, "result");
			if (mn.wb == 1) cmp(WB_ADDR, mn.a, "dest index");
			cmp(FLAGS, mn.f, "flags");
			cmp(PC, mn.pc, "pc");
			mc = 1;
			while (INSTR_READY !== 1'b1 && mc < 8) begin @(posedge CLOCK); #1; mc++; end
			cmp_len(mc, mn.n);
		end
	end

	task automatic check_reset();
		#1;
		cmp(PC, 12'h000, "reset pc");
		cmp(FLAGS, 8'h00, "reset flags");
		cmp(INSTR_READY, 1'b1, "reset ready");
		cmp(WB_VALID, 1'b0, "reset strobe");
		ef = 0; epc = 0; sp = 0; depth = 0;
	endtask

	task automatic final_report();
		$display("compares %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// hang guard, well beyond the roughly 600 cycles the tests need
	initial begin
		#(8000 * 50);
		error_cnt++;
		final_report();
	end

	initial begin
		CLOCK = 0; RESET = 1; INSTR_VALID = 0; OP = OP_NOP; DST_ADDR = 0; RD_DATA = 0; RR_DATA = 0;
		IMM_K = 0; BIT_SEL = 0; FLAG_SEL = 0; OFFSET = 0; IO_DATA = 0; SKIP_LONG = 0;
		error_cnt = 0; checked = 0;
		void'($urandom(14492));
		repeat (5) @(posedge CLOCK);
		RESET <= 0;
		check_reset();
		$display("test reset done");
		@(posedge CLOCK);
		// carry, half-carry, zero and overflow corners
		issue(OP_ADD, 5'h01, 8'hFF, 8'h01, 8'h00, 3'h0, 3'h0, 12'h000, 8'h00, 1'b0);
		issue(OP_ADD_CARRY, 5'h02, 8'h7F, 8'h00, 8'h00, 3'h0, 3'h0, 12'h000, 8'h00, 1'b0);
		issue(OP_IMMEDIATE_BORROW_DIFFERENCE, 5'h03, 8'h00, 8'h00, 8'h00, 3'h0, 3'h0, 12'h000, 8'h00, 1'b0);
		$display("test corners done");
		// every op once in code order (interrupt return becomes a call), then random back-to-back traffic
		for (i = 0; i < 400; i++) begin
			rv = {$urandom, $urandom};
			o = (i < 29) ? aeb_op_t'(i) : aeb_op_t'($urandom_range(28, 0));
			if (o inside {OP_SUBROUTINE_RETURN, OP_INTERRUPT_RETURN} && depth == 0) o = OP_RELATIVE_SUBROUTINE_CALL;
			issue(o, rv[4:0], rv[12:5], rv[56] ? rv[12:5] : rv[20:13], rv[28:21], rv[31:29], rv[34:32],
				rv[46:35], rv[54:47], rv[55]);
		end
		INSTR_VALID <= 0;
		repeat (6) @(posedge CLOCK);
		$display("test random done");
		// reset again with flags, pc and stack all busy
		RESET <= 1;
		repeat (2) @(posedge CLOCK);
		RESET <= 0;
		check_reset();
		@(posedge CLOCK);
		issue(OP_RELATIVE_SUBROUTINE_CALL, 5'h00, 8'h00, 8'h00, 8'h00, 3'h0, 3'h0, 12'hFF0, 8'h00, 1'b0);
		issue(OP_INTERRUPT_RETURN, 5'h00, 8'h00, 8'h00, 8'h00, 3'h0, 3'h0, 12'h000, 8'h00, 1'b0);
		// named branches on I, H, C and S, then a long equal skip and an I/O bit skip
		issue(OP_FLAG_SET_BRANCH, 5'h00, 8'h00, 8'h00, 8'h00, 3'h0, 3'h7, 12'h010, 8'h00, 1'b0);
		issue(OP_FLAG_CLEAR_BRANCH, 5'h00, 8'h00, 8'h00, 8'h00, 3'h0, 3'h5, 12'h020, 8'h00, 1'b0);
		issue(OP_FLAG_CLEAR_BRANCH, 5'h00, 8'h00, 8'h00, 8'h00, 3'h0, 3'h0, 12'hFFE, 8'h00, 1'b0);
		issue(OP_FLAG_SET_BRANCH, 5'h00, 8'h00, 8'h00, 8'h00, 3'h0, 3'h4, 12'h030, 8'h00, 1'b0);
		issue(OP_EQUAL_COMPARE_SKIP, 5'h00, 8'h5A, 8'h5A, 8'h00, 3'h0, 3'h0, 12'h000, 8'h00, 1'b1);
		issue(OP_SKIP_ON_IO_BIT_HIGH, 5'h00, 8'h00, 8'h00, 8'h00, 3'h3, 3'h0, 12'h000, 8'h08, 1'b0);
		INSTR_VALID <= 0;
		repeat (6) @(posedge CLOCK);
		$display("test rereset done");
		final_report();
	end
endmodule // alu_and_branch_execution_test
